// ### design/fsl_pkg.sv
// Shared constants and types for the floppy support logic block.
// Assumes one 100 MHz APB clock; every pin is sampled into that domain.
package fsl_pkg;

  // Clock rate and pin synchroniser layout.
  localparam int unsigned FSL_CLK_MHZ = 100;
  localparam int unsigned FSL_SYNC_W = 13;
  localparam int unsigned FSL_S_VCO = 0;
  localparam int unsigned FSL_S_WR = 1;
  localparam int unsigned FSL_S_PH1 = 2;
  localparam int unsigned FSL_S_PH4 = 5;
  localparam int unsigned FSL_S_WG = 6;
  localparam int unsigned FSL_S_VFOE = 7;
  localparam int unsigned FSL_S_TRK = 8;
  localparam int unsigned FSL_S_RDD = 9;
  localparam int unsigned FSL_S_DDN = 10;
  localparam int unsigned FSL_S_EARLY = 11;
  localparam int unsigned FSL_S_LATE = 12;
  // Pulled-up pins (inner track, raw read, density select) start high.
  localparam logic [12:0] FSL_SYNC_RST = 13'h0700;

  // Read-window divider.
  localparam logic [3:0] FSL_DIV_LAST = 4'hf;
  localparam logic [3:0] FSL_DIV_MID = 4'h7;
  // Window positions: with a 4-tick window 1..2 are centre, with 8 ticks 3..4.
  localparam logic [2:0] FSL_DD_CTR_LO = 3'h1;
  localparam logic [2:0] FSL_DD_CTR_HI = 3'h2;
  localparam logic [2:0] FSL_SD_CTR_LO = 3'h3;
  localparam logic [2:0] FSL_SD_CTR_HI = 3'h4;

  // Register map (byte addresses).
  localparam int unsigned FSL_AW = 8;
  localparam logic [7:0] FSL_CTRL_OFF = 8'h00;
  localparam logic [7:0] FSL_STAT_OFF = 8'h04;
  localparam logic [7:0] FSL_LOG_OFF = 8'h08;
  localparam int unsigned FSL_CTRL_PUMP_EN = 0;
  localparam int unsigned FSL_CTRL_BYPASS = 1;
  localparam logic [1:0] FSL_CTRL_RST = 2'h1;
  localparam int unsigned FSL_STAT_OVR = 1;
  localparam int unsigned FSL_LOG_VALID = 8;
  localparam int unsigned FSL_BUF_DEPTH = 2;

  typedef enum logic [1:0] {
    FSL_PUMP_IDLE = 2'b00,
    FSL_PUMP_UP = 2'b01,
    FSL_PUMP_DOWN = 2'b10
  } fsl_pump_t;

  typedef enum logic [1:0] {
    FSL_PH1 = 2'b00,
    FSL_PH2 = 2'b01,
    FSL_PH3 = 2'b10
  } fsl_phase_t;

  typedef struct packed {
    logic bypass;
    logic pump_en;
  } fsl_ctrl_t;

  // One read-window verdict, as logged for software.
  typedef struct packed {
    fsl_pump_t verdict;
    logic [2:0] position;
  } fsl_log_t;

  localparam int unsigned FSL_LOG_W = $bits(fsl_log_t);

endpackage

// ### design/fsl_buf.sv
// Small valid/ready buffer holding logged read-window verdicts.
// Assumes both sides sit on pclk; depth of two lets one pop stall cost nothing.
`timescale 1ns/1ps
`default_nettype none
module fsl_buf
  import fsl_pkg::*;
#(
  parameter int unsigned WIDTH = FSL_LOG_W,
  parameter int unsigned DEPTH = FSL_BUF_DEPTH
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Filling side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] FULL = (PW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] count;
  logic push;
  logic pop;

  assign in_ready = (count != FULL);
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge pclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  buf_bounds_a: assert property (count <= FULL)
    else $error("buffer count beyond depth");
  buf_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("buffer head lost without pop");

endmodule
`default_nettype wire

// ### design/fsl_top.sv
// Floppy support logic: read-window clock, pump steering and write precomp.
// Assumes every pin is asynchronous to pclk and is sampled far faster than it moves.
// Summary of operation
// - Write pulse leading edge sets strobe high.
// - Fourth phase leading edge clears the strobe.
// - Write gate high floats both pumps.
// - Recovery needs write gate and enable low.
// - Pumps float while raw read is high.
// - Early read edge drives pump increase high.
// - Late read edge drives pump decrease low.
// - Centred read edge leaves both pumps floating.
// - Window clock is VCO over 16 or 8.
// - Pump stays active while raw read low.
// - Double density on inner tracks picks phase on write edge.
// - Nominal phase two, late three, early one.
// - Bypass passes write pulses straight through.
// - Pulled-up inputs read high when open.
`timescale 1ns/1ps
`default_nettype none
module fsl_top
  import fsl_pkg::*;
(
  // APB slave.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [FSL_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Controller and drive pins.
  input wire logic vco_in,
  input wire logic write_pulse_in,
  input wire logic [3:0] phase_in,
  input wire logic write_gate_in,
  input wire logic recovery_enable_fault_in,
  input wire logic inner_track_flag,
  input wire logic raw_read_in,
  input wire logic double_density_sel_n,
  input wire logic early_in,
  input wire logic late_in,
  // Outputs to controller, clock generator and drive.
  output logic read_clock,
  output logic precomp_strobe,
  output logic write_pulse_out,
  output logic pump_increase_o,
  output logic pump_increase_oe,
  output logic pump_decrease_o,
  output logic pump_decrease_oe
);

  logic [FSL_SYNC_W-1:0] pins;
  logic [FSL_SYNC_W-1:0] sync1;
  logic [FSL_SYNC_W-1:0] sync2;
  logic vco_prev;
  logic wr_prev;
  logic ph4_prev;
  logic rdd_prev;
  logic vco_tick;
  logic wr_lead;
  logic ph4_lead;
  logic rd_fall;
  logic wg_s;
  logic rdd_s;
  logic sd_s;
  logic wr_s;
  logic rec_en;
  logic precomp_on;
  logic [3:0] div_cnt;
  logic [3:0] next_div_cnt;
  logic [2:0] win_pos;
  logic pos_early;
  logic pos_late;
  fsl_pump_t pump_state;
  fsl_pump_t next_verdict;
  fsl_phase_t phase_sel;
  fsl_ctrl_t ctrl;
  logic overrun;
  fsl_log_t log_rec;
  logic log_pend;
  logic buf_in_ready;
  logic buf_out_valid;
  fsl_log_t buf_out_data;
  logic apb_access;
  logic apb_done;
  logic addr_ok;

  // Phase decode used by the write output.
  function automatic logic phase_level(input fsl_phase_t sel, input logic [3:0] ph);
    case (sel)
      FSL_PH1: phase_level = ph[0];
      FSL_PH2: phase_level = ph[1];
      FSL_PH3: phase_level = ph[2];
      default: phase_level = ph[1];
    endcase
  endfunction

  assign pins = {late_in, early_in, double_density_sel_n, raw_read_in, inner_track_flag,
                 recovery_enable_fault_in, write_gate_in, phase_in, write_pulse_in, vco_in};

  // Open pins reach the block as high through pad pull-ups; until sampled they read high.
  // pulled-up defaults
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= FSL_SYNC_RST;
      sync2 <= FSL_SYNC_RST;
    end else begin
      sync1 <= pins;
      sync2 <= sync1;
    end
  end

  assign wg_s = sync2[FSL_S_WG];
  assign rdd_s = sync2[FSL_S_RDD];
  assign sd_s = sync2[FSL_S_DDN];
  assign wr_s = sync2[FSL_S_WR];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vco_prev <= 1'b0;
      wr_prev <= 1'b0;
      ph4_prev <= 1'b0;
      rdd_prev <= 1'b1;
    end else begin
      vco_prev <= sync2[FSL_S_VCO];
      wr_prev <= wr_s;
      ph4_prev <= sync2[FSL_S_PH4];
      rdd_prev <= rdd_s;
    end
  end

  assign vco_tick = sync2[FSL_S_VCO] && !vco_prev;
  assign wr_lead = wr_s && !wr_prev;
  assign ph4_lead = sync2[FSL_S_PH4] && !ph4_prev;
  assign rd_fall = !rdd_s && rdd_prev;

  assign rec_en = !wg_s && !sync2[FSL_S_VFOE] && ctrl.pump_en;

  assign next_div_cnt = vco_tick ? div_cnt + 4'h1 : div_cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= '0;
      read_clock <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      read_clock <= sd_s ? next_div_cnt[3] : next_div_cnt[2];
    end
  end

  // A window is one read clock level: 8 ticks in single density, 4 in double.
  assign win_pos = sd_s ? div_cnt[2:0] : {1'b0, div_cnt[1:0]};
  assign pos_early = sd_s ? (win_pos < FSL_SD_CTR_LO) : (win_pos < FSL_DD_CTR_LO);
  assign pos_late = sd_s ? (win_pos > FSL_SD_CTR_HI) : (win_pos > FSL_DD_CTR_HI);

  always_comb begin
    next_verdict = FSL_PUMP_IDLE;
    if (pos_early) begin
      next_verdict = FSL_PUMP_UP;
    end else if (pos_late) begin
      next_verdict = FSL_PUMP_DOWN;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pump_state <= FSL_PUMP_IDLE;
    end else if (!rec_en || rdd_s) begin
      pump_state <= FSL_PUMP_IDLE;
    end else if (rd_fall) begin
      pump_state <= next_verdict;
    end
  end

  // Pumps hold for the whole low read pulse; the verdict taken at its falling edge holds however long it lasts.
  // float while read high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pump_increase_oe <= 1'b0;
      pump_decrease_oe <= 1'b0;
      pump_increase_o <= 1'b1;
      pump_decrease_o <= 1'b0;
    end else begin
      pump_increase_o <= 1'b1;
      pump_decrease_o <= 1'b0;
      case (pump_state)
        FSL_PUMP_UP: begin
          pump_increase_oe <= rec_en && !rdd_s;
          pump_decrease_oe <= 1'b0;
        end
        FSL_PUMP_DOWN: begin
          pump_increase_oe <= 1'b0;
          pump_decrease_oe <= rec_en && !rdd_s;
        end
        default: begin
          pump_increase_oe <= 1'b0;
          pump_decrease_oe <= 1'b0;
        end
      endcase
    end
  end

  assign precomp_on = !sd_s && sync2[FSL_S_TRK] && !ctrl.bypass;

  // early one, nominal two, late three
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_sel <= FSL_PH2;
    end else if (wr_lead && precomp_on) begin
      if (sync2[FSL_S_LATE]) begin
        phase_sel <= FSL_PH3;
      end else if (sync2[FSL_S_EARLY]) begin
        phase_sel <= FSL_PH1;
      end else begin
        phase_sel <= FSL_PH2;
      end
    end
  end

  // A new write edge wins over a fourth-phase clear in the same cycle.
  // strobe set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      precomp_strobe <= 1'b0;
    end else if (wr_lead) begin
      precomp_strobe <= 1'b1;
    end else if (ph4_lead) begin
      precomp_strobe <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      write_pulse_out <= 1'b0;
    end else if (!precomp_on) begin
      write_pulse_out <= wr_s;
    end else begin
      write_pulse_out <= precomp_strobe && phase_level(phase_sel, sync2[FSL_S_PH4:FSL_S_PH1]);
    end
  end

  // Verdict log; a full buffer holds the pending record and later ones count as overrun.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      log_pend <= 1'b0;
      log_rec <= '0;
    end else if (rd_fall && rec_en && (!log_pend || buf_in_ready)) begin
      log_pend <= 1'b1;
      log_rec <= '{verdict: next_verdict, position: win_pos};
    end else if (buf_in_ready) begin
      log_pend <= 1'b0;
    end
  end

  fsl_buf #(.WIDTH(FSL_LOG_W), .DEPTH(FSL_BUF_DEPTH)) u_log_buf (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(log_pend),
    .in_ready(buf_in_ready),
    .in_data(log_rec),
    .out_valid(buf_out_valid),
    .out_ready(apb_done && !pwrite && (paddr == FSL_LOG_OFF)),
    .out_data(buf_out_data)
  );

  // APB: answer on the second access cycle so outputs come from flops.
  assign apb_access = psel && penable;
  assign apb_done = apb_access && pready;
  assign addr_ok = (paddr == FSL_CTRL_OFF) || (paddr == FSL_STAT_OFF) ||
                   (paddr == FSL_LOG_OFF);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= apb_access && !pready;
      pslverr <= apb_access && !pready && !addr_ok;
      prdata <= '0;
      if (apb_access && !pready && !pwrite) begin
        case (paddr)
          FSL_CTRL_OFF: prdata <= {30'h0, ctrl};
          FSL_STAT_OFF: prdata <= {24'h0, pump_state, sd_s, precomp_strobe,
                                   buf_out_valid, log_pend, overrun, rec_en};
          FSL_LOG_OFF: prdata <= {23'h0, buf_out_valid, 3'h0, buf_out_data};
          default: prdata <= '0;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= FSL_CTRL_RST;
    end else if (apb_done && pwrite && (paddr == FSL_CTRL_OFF)) begin
      ctrl <= '{bypass: pwdata[FSL_CTRL_BYPASS], pump_en: pwdata[FSL_CTRL_PUMP_EN]};
    end
  end

  // A lost verdict in the clearing cycle still sets the flag.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overrun <= 1'b0;
    end else if (rd_fall && rec_en && log_pend && !buf_in_ready) begin
      overrun <= 1'b1;
    end else if (apb_done && pwrite && (paddr == FSL_STAT_OFF) && pwdata[FSL_STAT_OVR]) begin
      overrun <= 1'b0;
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence wr_edge_s;
    wr_lead;
  endsequence
  sequence ph4_only_s;
    ph4_lead && !wr_lead;
  endsequence
  sequence read_start_s(logic cls);
    rd_fall && rec_en && cls ##1 (rec_en && !rdd_s);
  endsequence

  strobe_set_a: assert property (wr_edge_s |=> precomp_strobe)
    else $error("strobe not set by write edge");
  strobe_clear_a: assert property (ph4_only_s |=> !precomp_strobe)
    else $error("strobe not cleared by fourth phase");
  gate_float_a: assert property (wg_s |=> !pump_increase_oe && !pump_decrease_oe)
    else $error("pump driven during write gate");
  enable_float_a: assert property (!rec_en |=> !pump_increase_oe && !pump_decrease_oe)
    else $error("pump driven while recovery off");
  read_high_a: assert property (rdd_s |=> !pump_increase_oe && !pump_decrease_oe)
    else $error("pump driven while raw read high");
  early_up_a: assert property (read_start_s(pos_early) |=> pump_increase_oe &&
                               pump_increase_o && !pump_decrease_oe)
    else $error("early edge did not raise pump increase");
  late_down_a: assert property (read_start_s(pos_late) |=> pump_decrease_oe &&
                                !pump_decrease_o && !pump_increase_oe)
    else $error("late edge did not drive pump decrease");
  centre_idle_a: assert property (read_start_s(!pos_early && !pos_late) |=>
                                  !pump_increase_oe && !pump_decrease_oe)
    else $error("centred edge drove a pump");
  divide_wrap_a: assert property (vco_tick && div_cnt == FSL_DIV_MID |=>
                                  read_clock == $past(sd_s))
    else $error("read clock wrong at mid count");
  divide_end_a: assert property (vco_tick && div_cnt == FSL_DIV_LAST |=> !read_clock)
    else $error("read clock not low after wrap");
  pump_hold_a: assert property (pump_increase_oe && rec_en && !rdd_s && !rd_fall &&
                                $stable(rec_en) |=> pump_increase_oe)
    else $error("pump increase ended during low pulse");
  late_phase_a: assert property (wr_lead && precomp_on && sync2[FSL_S_LATE] |=>
                                 phase_sel == FSL_PH3)
    else $error("late flag did not pick phase three");
  nominal_phase_a: assert property (wr_lead && precomp_on && !sync2[FSL_S_LATE] &&
                                    !sync2[FSL_S_EARLY] |=> phase_sel == FSL_PH2)
    else $error("nominal write did not pick phase two");
  bypass_pass_a: assert property (!precomp_on |=> write_pulse_out == $past(wr_s))
    else $error("bypass did not pass write pulse");

endmodule
`default_nettype wire

// ### bench/fsl_far_model.sv
// Far-side model: free-running VCO and a four-phase generator started by the strobe.
// Assumes the strobe comes from the block; the phases are non-overlapping pulses.
`timescale 1ns/1ps
`default_nettype none
module fsl_far_model #(
  parameter int VCO_HALF_NS = 125,
  parameter int PHASE_CYC = 10
) (
  // Clock and strobe from the block.
  input wire logic pclk,
  input wire logic precomp_strobe,
  // Pins driven toward the block.
  output logic vco_in,
  output logic [3:0] phase_in
);
  // Nominal VCO rate.
  // The start offset keeps VCO edges off the pclk edges, so sampling never races.
  initial begin
    vco_in = 1'b0;
    #2;
    forever #(VCO_HALF_NS) vco_in = ~vco_in;
  end

  // Phases one to four follow each rising strobe, phase four last.
  initial begin
    phase_in = 4'h0;
    forever begin
      @(posedge precomp_strobe);
      repeat (8) @(posedge pclk);
      for (int i = 0; i < 4; i++) begin
        phase_in <= 4'h1 << i;
        repeat (PHASE_CYC) @(posedge pclk);
        phase_in <= 4'h0;
        repeat (2) @(posedge pclk);
      end
    end
  end
endmodule
`default_nettype wire

// ### bench/fsl_top_tb.sv
// Bench for the floppy support logic: APB registers, window clock, pumps and precomp.
// Assumes the far-side model makes the VCO and phases; the bench plays controller and drive.
`timescale 1ns/1ps
`default_nettype none
module fsl_top_tb import fsl_pkg::*;;
  localparam int VCO_CYC = 25;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic vco_in, write_pulse_in, write_gate_in, recovery_enable_fault_in;
  logic inner_track_flag, raw_read_in, double_density_sel_n, early_in, late_in;
  logic [3:0] phase_in;
  logic read_clock, precomp_strobe, write_pulse_out;
  logic pump_increase_o, pump_increase_oe, pump_decrease_o, pump_decrease_oe;
  wire pump_up_pin;
  wire pump_down_pin;
  int errors, compares, pump_cyc;

  assign pump_up_pin = pump_increase_oe ? pump_increase_o : 1'bz;
  assign pump_down_pin = pump_decrease_oe ? pump_decrease_o : 1'bz;

  fsl_top u_fsl_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .vco_in(vco_in),
    .write_pulse_in(write_pulse_in), .phase_in(phase_in),
    .write_gate_in(write_gate_in), .recovery_enable_fault_in(recovery_enable_fault_in),
    .inner_track_flag(inner_track_flag), .raw_read_in(raw_read_in),
    .double_density_sel_n(double_density_sel_n), .early_in(early_in), .late_in(late_in),
    .read_clock(read_clock), .precomp_strobe(precomp_strobe),
    .write_pulse_out(write_pulse_out), .pump_increase_o(pump_increase_o),
    .pump_increase_oe(pump_increase_oe), .pump_decrease_o(pump_decrease_o),
    .pump_decrease_oe(pump_decrease_oe)
  );

  fsl_far_model #(.VCO_HALF_NS(125), .PHASE_CYC(10)) u_fsl_far_model (
    .pclk(pclk), .precomp_strobe(precomp_strobe), .vco_in(vco_in), .phase_in(phase_in)
  );

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    if (pump_increase_oe | pump_decrease_oe) pump_cyc++;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // One APB transfer; the request stands until pready is seen high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends this wait, so a slave that never answers fails the run.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic apb_rd(input logic [7:0] a, output logic [31:0] d);
    logic e;
    apb(1'b0, a, 32'h0, d, e);
    check("rd_err", e, a > 8'h08);
  endtask

  task automatic apb_wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] d;
    logic e;
    apb(1'b1, a, wd, d, e);
    check("wr_err", e, a > 8'h08);
  endtask

  task automatic wait_rc(input logic v, output int n);
    n = 0;
    while (read_clock !== v) begin
      @(posedge pclk);
      n++;
    end
  endtask

  task automatic t_regs;
    logic [31:0] d;
    apb_rd(FSL_CTRL_OFF, d);
    check("ctrl_rst", d, 32'h1);
    apb_wr(8'h0c, 32'h2);
    apb_rd(8'h0c, d);
    check("unmapped", d, 32'h0);
    apb_wr(FSL_CTRL_OFF, 32'h2);
    apb_rd(FSL_CTRL_OFF, d);
    check("ctrl_rw", d, 32'h2);
    apb_wr(FSL_CTRL_OFF, 32'h1);
  endtask

  task automatic t_divider(input logic sd, input int per);
    int a, b;
    double_density_sel_n <= sd;
    repeat (5) @(posedge pclk);
    wait_rc(1'b0, a);
    wait_rc(1'b1, a);
    wait_rc(1'b0, a);
    wait_rc(1'b1, b);
    check("rc_period", a + b, per);
  endtask

  task automatic t_pump(input int ticks, input logic wg, input logic ven, input logic up,
      input logic dn);
    int n;
    logic v;
    write_gate_in <= wg;
    recovery_enable_fault_in <= ven;
    v = read_clock;
    wait_rc(~v, n);
    repeat (ticks) @(posedge vco_in);
    repeat (5) @(posedge pclk);
    check("pump_idle", {pump_increase_oe, pump_decrease_oe}, 2'b00);
    pump_cyc = 0;
    raw_read_in <= 1'b0;
    repeat (12) @(posedge pclk);
    check("pump_up", pump_up_pin, up ? 1'b1 : 1'bz);
    check("pump_down", pump_down_pin, dn ? 1'b0 : 1'bz);
    repeat (8) @(posedge pclk);
    raw_read_in <= 1'b1;
    repeat (4) @(posedge pclk);
    check("pump_float", {pump_increase_oe, pump_decrease_oe}, 2'b00);
    check("pump_len", pump_cyc > 16 && pump_cyc < 22, up | dn);
  endtask

  task automatic t_log;
    logic [31:0] d;
    logic [31:0] exp [3];
    exp = '{32'h108, 32'h101, 32'h113};
    apb_rd(FSL_STAT_OFF, d);
    check("stat_full", d & 32'h0a, 32'h0a);
    for (int i = 0; i < 3; i++) begin
      apb_rd(FSL_LOG_OFF, d);
      check("log_entry", d, exp[i]);
    end
    apb_rd(FSL_LOG_OFF, d);
    check("log_empty", d[8], 1'b0);
    apb_wr(FSL_STAT_OFF, 32'h2);
    apb_rd(FSL_STAT_OFF, d);
    check("stat_clear", d & 32'h0a, 32'h0);
  endtask

  task automatic t_wr(input logic e, input logic l, input logic trk, input logic sd,
      input logic [3:0] ph);
    early_in <= e;
    late_in <= l;
    inner_track_flag <= trk;
    double_density_sel_n <= sd;
    repeat (12) @(posedge pclk);
    write_pulse_in <= 1'b1;
    repeat (6) @(posedge pclk);
    write_pulse_in <= 1'b0;
    check("strobe_set", precomp_strobe, 1'b1);
    // The watchdog bounds both waits, so a missing pulse or clear fails the run.
    while (write_pulse_out !== 1'b1) begin
      @(posedge pclk);
    end
    check("out_phase", phase_in, ph);
    while (precomp_strobe !== 1'b0) begin
      @(posedge pclk);
    end
    check("strobe_clr", phase_in, 4'h8);
    repeat (30) @(posedge pclk);
  endtask

  initial begin
    #400000;
    errors++;
    finish_test();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    write_pulse_in = 1'b0;
    write_gate_in = 1'b0;
    recovery_enable_fault_in = 1'b0;
    inner_track_flag = 1'b1;
    raw_read_in = 1'b1;
    double_density_sel_n = 1'b1;
    early_in = 1'b0;
    late_in = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_divider(1'b1, 16 * VCO_CYC);
    t_divider(1'b0, 8 * VCO_CYC);
    t_pump(0, 1'b1, 1'b0, 1'b0, 1'b0);
    t_pump(0, 1'b0, 1'b1, 1'b0, 1'b0);
    t_pump(0, 1'b0, 1'b0, 1'b1, 1'b0);
    t_pump(1, 1'b0, 1'b0, 1'b0, 1'b0);
    t_pump(3, 1'b0, 1'b0, 1'b0, 1'b1);
    t_pump(0, 1'b0, 1'b0, 1'b1, 1'b0);
    t_log();
    apb_wr(FSL_CTRL_OFF, 32'h0);
    t_pump(0, 1'b0, 1'b0, 1'b0, 1'b0);
    apb_wr(FSL_CTRL_OFF, 32'h1);
    t_wr(1'b0, 1'b0, 1'b1, 1'b0, 4'h2);
    t_wr(1'b1, 1'b0, 1'b1, 1'b0, 4'h1);
    t_wr(1'b0, 1'b1, 1'b1, 1'b0, 4'h4);
    t_wr(1'b1, 1'b1, 1'b1, 1'b0, 4'h4);
    t_wr(1'b0, 1'b0, 1'b0, 1'b0, 4'h0);
    t_wr(1'b0, 1'b0, 1'b1, 1'b1, 4'h0);
    // Single-density wiring: density select left high as if open, inner track grounded.
    t_wr(1'b0, 1'b0, 1'b0, 1'b1, 4'h0);
    // Software bypass must pass write pulses even with precomp pins asking for it.
    apb_wr(FSL_CTRL_OFF, 32'h3);
    t_wr(1'b0, 1'b0, 1'b1, 1'b0, 4'h0);
    finish_test();
  end
endmodule
`default_nettype wire
